// file: include/mef_pkg.sv
// ----------------------------------------------------------------------------
// Metering event status flags: shared constants
// ----------------------------------------------------------------------------
package mef_pkg;

  // Register word indices (byte address is four times the index)
  localparam logic [15:0] IDX_STATUS_FIRST  = 16'hE502;
  localparam logic [15:0] IDX_STATUS_SECOND = 16'hE503;
  localparam logic [15:0] IDX_SIGN          = 16'hE504;
  localparam logic [15:0] IDX_PULSE_MODE    = 16'hE505;
  localparam logic [15:0] IDX_NOLOAD_PHASE  = 16'hE506;
  localparam logic [15:0] IDX_ACC_MODE      = 16'hE507;
  localparam logic [15:0] IDX_VARIANT       = 16'hE508;

  // First status register bit positions
  localparam int B1_REACT_C   = 12;
  localparam int B1_SUM2      = 13;
  localparam int B1_PULSE1    = 14;
  localparam int B1_PULSE2    = 15;
  localparam int B1_PULSE3    = 16;
  localparam int B1_DSP_DONE  = 17;
  localparam int B1_SUM3      = 18;
  localparam logic [31:0] FIRST_MASK = 32'h0007_F000;

  // Second status register bit positions
  localparam int B2_TOTAL_NL  = 0;
  localparam int B2_FUND_NL   = 1;
  localparam int B2_APP_NL    = 2;
  localparam int B2_VTO_LO    = 3;
  localparam int B2_ITO_LO    = 6;
  localparam int B2_VZX_LO    = 9;
  localparam logic [31:0] SECOND_MASK = 32'h0000_0FFF;

  // Sign register bit positions
  localparam int S_REACT_C = 6;
  localparam int S_SUM2    = 7;
  localparam int S_SUM3    = 8;

  // Pulse output mode register fields
  localparam int PM_SEL1_LO = 0;
  localparam int PM_SEL2_LO = 3;
  localparam int PM_SEL3_LO = 6;
  localparam int PM_DIS1    = 9;
  localparam int PM_DIS2    = 10;
  localparam int PM_DIS3    = 11;
  localparam logic [11:0] PM_RESET = 12'h0E88;

  // Accumulation mode: reactive sign source select bit
  localparam int AM_REACT_SEL = 7;

  // No-load phase register fields
  localparam int NL_TOTAL_LO = 0;
  localparam int NL_FUND_LO  = 3;
  localparam int NL_APP_LO   = 6;

  // Variant capability bits (arbitrary default: full feature set)
  localparam int V_HAS_REACT = 0;
  localparam int V_HAS_FUND  = 1;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED  = 32'h0000_0000;

endpackage

// file: rtl/mef_fall_detect.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Falling edge detector for a group of pins, two-flop synchronised
// ----------------------------------------------------------------------------
module mef_fall_detect #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Pins and pulses
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] fall_pulse
);

  logic [W-1:0] sync1_reg;
  logic [W-1:0] sync2_reg;
  logic [W-1:0] last_reg;

  // Idle level of an active-low pulse output is high
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= {W{1'b1}};
      sync2_reg <= {W{1'b1}};
      last_reg  <= {W{1'b1}};
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
    end
  end

  // The second stage is compared with the flop behind it
  assign fall_pulse = last_reg & ~sync2_reg;

endmodule
`default_nettype wire

// file: rtl/mef_sign_watch.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Sign tracker: records a sign and pulses when it changes
// ----------------------------------------------------------------------------
module mef_sign_watch (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Sign sample
  input  wire logic sample_en,
  input  wire logic sign_in,
  output logic      sign_reg,
  output logic      change_pulse
);

  logic seen_reg;

  // First sample after reset only primes the tracker
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sign_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else if (sample_en) begin
      sign_reg <= sign_in;
      seen_reg <= 1'b1;
    end
  end

  assign change_pulse = sample_en & seen_reg & (sign_in != sign_reg);

endmodule
`default_nettype wire

// file: rtl/mef_status_flags.sv
// Our own choice: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Flag bit 12 when chosen phase C reactive power changes sign; sign bit 6.
// - Reduced variants read phase C reactive and fundamental no-load as 0.
// - Flag bit 13 when second pulse path power sum changes sign; sign bit 7.
// - Flag bit 18 when third pulse datapath power sum changes sign; sign bit 8.
// - Flag bit 14 on falling edge of the first pulse output.
// - Flag bits 15 and 16 on falling edges of second and third pulse outputs.
// - Pulse flags still set while the pulse pin output is disabled.
// - Pulse mode fields [2:0], [5:3], [8:6] select power type per output.
// - Flag bit 17 each time the periodic processing cycle completes.
// - First status bits 31 to 19 always read zero.
// - Second status bit 0 on total no-load entry; phases in bits [2:0].
// - Second status bit 1 on fundamental no-load entry; phases in bits [5:3].
// - Second status bit 2 on apparent no-load entry; phases in bits [8:6].
// - Second status bits 3..5 on missing voltage zero crossing, phases A..C.
// - Second status bits 6..8 on missing current zero crossing, phases A..C.
// - Second status bits 9..11 on voltage zero crossing, phases A..C.
module mef_status_flags (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Signal processing events (same clock domain)
  input  wire logic        dsp_cycle_done,
  input  wire logic        react_c_total_sign,
  input  wire logic        react_c_fund_sign,
  input  wire logic        sum_two_sign_in,
  input  wire logic        sum_three_sign_in,
  input  wire logic [2:0]  total_noload_enter,
  input  wire logic [2:0]  fund_noload_enter,
  input  wire logic [2:0]  app_noload_enter,
  input  wire logic [2:0]  volt_timeout_evt,
  input  wire logic [2:0]  curr_timeout_evt,
  input  wire logic [2:0]  volt_crossing_evt,
  // Pulse output pins as driven internally (active low)
  input  wire logic        pulse_out_one,
  input  wire logic        pulse_out_two,
  input  wire logic        pulse_out_three,
  // Configuration to the pulse generators
  output logic [2:0]       pulse_one_power_select,
  output logic [2:0]       pulse_two_power_select,
  output logic [2:0]       pulse_three_power_select,
  output logic             pulse_one_disable,
  output logic             pulse_two_disable,
  output logic             pulse_three_disable
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  logic [31:0] status_first_reg;
  logic [31:0] status_second_reg;
  logic [11:0] pulse_mode_reg;
  logic [31:0] acc_mode_reg;
  logic [1:0]  variant_reg;
  logic [8:0]  noload_phase_reg;
  logic [31:0] avs_readdata_reg;
  logic        wait_reg;
  logic [31:0] status_first_next;
  logic [31:0] status_second_next;
  logic [31:0] wmask;
  logic [31:0] bmask;
  logic [31:0] clear_first;
  logic [31:0] clear_second;
  logic [31:0] set_first;
  logic [31:0] set_second;
  logic [31:0] sign_word;
  logic [31:0] read_word;
  logic [2:0]  pulse_fall;
  logic        react_sign_sel;
  logic        react_c_sign;
  logic        react_c_chg;
  logic        react_c_sign_q;
  logic        sum2_sign;
  logic        sum2_chg;
  logic        sum3_sign;
  logic        sum3_chg;
  logic        bus_write;
  logic        bus_read;

  // Byte enables widened to a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Address match helper used by every decode
  function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
    hit = (a == idx);
  endfunction

  // --------------------------------------------------------------------------
  // Bus handshake: one wait cycle, answer on the second
  // --------------------------------------------------------------------------
  // Waitrequest stays high for the first cycle of any request, where a read is registered; a write is
  // registered on the answer edge, where the master also takes the read data.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
    end else if ((avs_read || avs_write) && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign bus_write = avs_write & ~wait_reg;
  assign bus_read  = avs_read & wait_reg;
  assign bmask     = be_mask(avs_byteenable);
  assign wmask     = bmask & avs_writedata;

  // --------------------------------------------------------------------------
  // Event sources
  // --------------------------------------------------------------------------
  // Pulse pins are sampled through a two-flop synchroniser.
  mef_fall_detect #(
    .W (3)
  ) u_fall (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .pin_in     ({pulse_out_three, pulse_out_two, pulse_out_one}),
    .fall_pulse (pulse_fall)
  );

  // Reactive sign source: total or fundamental
  assign react_sign_sel = acc_mode_reg[mef_pkg::AM_REACT_SEL];
  assign react_c_sign   = react_sign_sel ? react_c_fund_sign
                                         : react_c_total_sign;

  // Signs are evaluated once per processing cycle
  mef_sign_watch u_react_c (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .sample_en    (dsp_cycle_done),
    .sign_in      (react_c_sign),
    .sign_reg     (react_c_sign_q),
    .change_pulse (react_c_chg)
  );

  mef_sign_watch u_sum2 (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .sample_en    (dsp_cycle_done),
    .sign_in      (sum_two_sign_in),
    .sign_reg     (sum2_sign),
    .change_pulse (sum2_chg)
  );

  mef_sign_watch u_sum3 (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .sample_en    (dsp_cycle_done),
    .sign_in      (sum_three_sign_in),
    .sign_reg     (sum3_sign),
    .change_pulse (sum3_chg)
  );

  // Sign register view
  always_comb begin
    sign_word = mef_pkg::ZERO_WORD;
    sign_word[mef_pkg::S_REACT_C] = react_c_sign_q &
                                    variant_reg[mef_pkg::V_HAS_REACT];
    sign_word[mef_pkg::S_SUM2] = sum2_sign;
    sign_word[mef_pkg::S_SUM3] = sum3_sign;
  end

  // --------------------------------------------------------------------------
  // Set terms for both status registers
  // --------------------------------------------------------------------------
  always_comb begin
    set_first = mef_pkg::ZERO_WORD;
    set_first[mef_pkg::B1_REACT_C] = react_c_chg &
                                     variant_reg[mef_pkg::V_HAS_REACT];
    set_first[mef_pkg::B1_SUM2] = sum2_chg;
    set_first[mef_pkg::B1_SUM3] = sum3_chg;
    // Edges are taken regardless of the pin disable bits
    set_first[mef_pkg::B1_PULSE1] = pulse_fall[0];
    set_first[mef_pkg::B1_PULSE2] = pulse_fall[1];
    set_first[mef_pkg::B1_PULSE3] = pulse_fall[2];
    set_first[mef_pkg::B1_DSP_DONE] = dsp_cycle_done;
  end

  always_comb begin
    set_second = mef_pkg::ZERO_WORD;
    set_second[mef_pkg::B2_TOTAL_NL] = |total_noload_enter;
    set_second[mef_pkg::B2_FUND_NL]  = |fund_noload_enter &
                                       variant_reg[mef_pkg::V_HAS_FUND];
    set_second[mef_pkg::B2_APP_NL]   = |app_noload_enter;
    set_second[mef_pkg::B2_VTO_LO +: 3] = volt_timeout_evt;
    set_second[mef_pkg::B2_ITO_LO +: 3] = curr_timeout_evt;
    set_second[mef_pkg::B2_VZX_LO +: 3] = volt_crossing_evt;
  end

  // --------------------------------------------------------------------------
  // Sticky flags, write one to clear
  // --------------------------------------------------------------------------
  assign clear_first  = (bus_write && hit(avs_address,
                        mef_pkg::IDX_STATUS_FIRST)) ? wmask
                                                    : mef_pkg::ZERO_WORD;
  assign clear_second = (bus_write && hit(avs_address,
                        mef_pkg::IDX_STATUS_SECOND)) ? wmask
                                                     : mef_pkg::ZERO_WORD;

  // A new event in the clearing cycle survives the clear
  assign status_first_next  = ((status_first_reg & ~clear_first) | set_first)
                              & mef_pkg::FIRST_MASK;
  assign status_second_next = ((status_second_reg & ~clear_second)
                              | set_second) & mef_pkg::SECOND_MASK;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_first_reg  <= mef_pkg::ZERO_WORD;
      status_second_reg <= mef_pkg::ZERO_WORD;
    end else begin
      status_first_reg  <= status_first_next;
      status_second_reg <= status_second_next;
    end
  end

  // --------------------------------------------------------------------------
  // No-load phase record: phases that have entered no-load
  // --------------------------------------------------------------------------
  // Updated from the entry events; it tracks the latest entries only, as
  // the detectors themselves live elsewhere.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      noload_phase_reg <= 9'h000;
    end else begin
      if (|total_noload_enter) begin
        noload_phase_reg[mef_pkg::NL_TOTAL_LO +: 3] <= total_noload_enter;
      end
      if (|fund_noload_enter && variant_reg[mef_pkg::V_HAS_FUND]) begin
        noload_phase_reg[mef_pkg::NL_FUND_LO +: 3] <= fund_noload_enter;
      end
      if (|app_noload_enter) begin
        noload_phase_reg[mef_pkg::NL_APP_LO +: 3] <= app_noload_enter;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_mode_reg <= mef_pkg::PM_RESET;
      acc_mode_reg   <= mef_pkg::ZERO_WORD;
      variant_reg    <= 2'b11;
    end else if (bus_write) begin
      if (hit(avs_address, mef_pkg::IDX_PULSE_MODE)) begin
        pulse_mode_reg <= (pulse_mode_reg & ~bmask[11:0]) | wmask[11:0];
      end
      if (hit(avs_address, mef_pkg::IDX_ACC_MODE)) begin
        acc_mode_reg <= (acc_mode_reg & ~bmask) | wmask;
      end
      if (hit(avs_address, mef_pkg::IDX_VARIANT) && avs_byteenable[0]) begin
        variant_reg <= avs_writedata[1:0];
      end
    end
  end

  // Pulse generator controls, straight from the register
  assign pulse_one_power_select   = pulse_mode_reg[mef_pkg::PM_SEL1_LO +: 3];
  assign pulse_two_power_select   = pulse_mode_reg[mef_pkg::PM_SEL2_LO +: 3];
  assign pulse_three_power_select = pulse_mode_reg[mef_pkg::PM_SEL3_LO +: 3];
  assign pulse_one_disable        = pulse_mode_reg[mef_pkg::PM_DIS1];
  assign pulse_two_disable        = pulse_mode_reg[mef_pkg::PM_DIS2];
  assign pulse_three_disable      = pulse_mode_reg[mef_pkg::PM_DIS3];

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  always_comb begin
    read_word = mef_pkg::UNMAPPED;
    if (hit(avs_address, mef_pkg::IDX_STATUS_FIRST)) begin
      read_word = status_first_reg;
    end else if (hit(avs_address, mef_pkg::IDX_STATUS_SECOND)) begin
      read_word = status_second_reg;
    end else if (hit(avs_address, mef_pkg::IDX_SIGN)) begin
      read_word = sign_word;
    end else if (hit(avs_address, mef_pkg::IDX_PULSE_MODE)) begin
      read_word = {20'h00000, pulse_mode_reg};
    end else if (hit(avs_address, mef_pkg::IDX_NOLOAD_PHASE)) begin
      read_word = {23'h000000, noload_phase_reg};
    end else if (hit(avs_address, mef_pkg::IDX_ACC_MODE)) begin
      read_word = acc_mode_reg;
    end else if (hit(avs_address, mef_pkg::IDX_VARIANT)) begin
      read_word = {30'h00000000, variant_reg};
    end
  end

  // Read data captured in the wait cycle, held through the answer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_reg <= mef_pkg::ZERO_WORD;
    end else if (bus_read) begin
      avs_readdata_reg <= read_word;
    end
  end

  assign avs_readdata = avs_readdata_reg;

endmodule
`default_nettype wire

// file: verification/mef_status_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checker for the status flag block
// ----------------------------------------
module mef_status_monitor (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // Register bus
  input wire logic [15:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Pulse generator configuration
  input wire logic [2:0]  pulse_one_power_select,
  input wire logic [2:0]  pulse_two_power_select,
  input wire logic [2:0]  pulse_three_power_select,
  input wire logic        pulse_one_disable,
  input wire logic        pulse_two_disable,
  input wire logic        pulse_three_disable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic [31:0] last_second;
  logic        have_last;
  logic [11:0] cfg;

  // Configuration outputs packed as the mode register lays them out
  assign cfg = {pulse_three_disable, pulse_two_disable, pulse_one_disable,
                pulse_three_power_select, pulse_two_power_select,
                pulse_one_power_select};

  sequence rd_done(logic [15:0] a);
    !avs_waitrequest && avs_read && avs_address == a;
  endsequence

  sequence pm_write;
    !avs_waitrequest && avs_write &&
    avs_address == mef_pkg::IDX_PULSE_MODE;
  endsequence

  // Last second status word, less any bit a clear write may remove
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      last_second <= 32'h0000_0000;
      have_last   <= 1'b0;
    end else if (!avs_waitrequest && avs_write &&
                 avs_address == mef_pkg::IDX_STATUS_SECOND) begin
      last_second <= last_second & ~avs_writedata;
    end else if (!avs_waitrequest && avs_read &&
                 avs_address == mef_pkg::IDX_STATUS_SECOND) begin
      last_second <= avs_readdata;
      have_last   <= 1'b1;
    end
  end

  AST_WAIT_ONE: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not one cycle after request");
  AST_WAIT_STANDS: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_FIRST_RSVD: assert property (
    rd_done(mef_pkg::IDX_STATUS_FIRST) |-> avs_readdata[31:19] == 13'h0000)
    else $error("reserved first status bits not zero");
  AST_SEL_WRITE: assert property (
    pm_write ##0 avs_byteenable[1:0] == 2'b11
    |=> cfg[8:0] == $past(avs_writedata[8:0]))
    else $error("power selects do not follow mode write");
  AST_DIS_WRITE: assert property (
    pm_write ##0 avs_byteenable[1] |=> cfg[11:9] == $past(avs_writedata[11:9]))
    else $error("pulse disables do not follow mode write");
  AST_CFG_HOLD: assert property (
    !(!avs_waitrequest && avs_write &&
      avs_address == mef_pkg::IDX_PULSE_MODE) |=> $stable(cfg))
    else $error("pulse configuration changed without write");
  AST_CFG_RESET: assert property (
    $rose(rst_n) |-> cfg == mef_pkg::PM_RESET)
    else $error("pulse configuration wrong after reset");
  AST_STICKY_SECOND: assert property (
    rd_done(mef_pkg::IDX_STATUS_SECOND) ##0 have_last
    |-> (avs_readdata & last_second) == last_second)
    else $error("second status flag dropped without a write");
endmodule

bind mef_status_flags mef_status_monitor mef_status_monitor_i (
  .mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .pulse_one_power_select, .pulse_two_power_select,
  .pulse_three_power_select, .pulse_one_disable, .pulse_two_disable,
  .pulse_three_disable
);
`default_nettype wire

// file: verification/test_metering_event_status_flags.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Self-checking bench for the status flags
// ----------------------------------------
module test_metering_event_status_flags;
  logic        mclk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [15:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, e1, e2, clr, bm, cfgv;
  logic [3:0]  avs_byteenable, be;
  logic        dsp_cycle_done, react_c_total_sign, react_c_fund_sign;
  logic        sum_two_sign_in, sum_three_sign_in;
  logic        pulse_out_one, pulse_out_two, pulse_out_three;
  logic [2:0]  total_noload_enter, fund_noload_enter, app_noload_enter;
  logic [2:0]  volt_timeout_evt, curr_timeout_evt, volt_crossing_evt;
  logic [2:0]  pulse_one_power_select, pulse_two_power_select;
  logic [2:0]  pulse_three_power_select, tn, fn, an, vt, ct, vz;
  logic        pulse_one_disable, pulse_two_disable, pulse_three_disable;
  logic        rt, rf, s2, s3, ch, pr, p2, p3, sel, primed;
  logic [11:0] pm;
  logic [8:0]  cur;
  int          error_cnt, tests_run, seed, k;

  mef_status_flags mef_status_flags_i (
    .mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .dsp_cycle_done,
    .react_c_total_sign, .react_c_fund_sign, .sum_two_sign_in,
    .sum_three_sign_in, .total_noload_enter, .fund_noload_enter,
    .app_noload_enter, .volt_timeout_evt, .curr_timeout_evt,
    .volt_crossing_evt, .pulse_out_one, .pulse_out_two, .pulse_out_three,
    .pulse_one_power_select, .pulse_two_power_select,
    .pulse_three_power_select, .pulse_one_disable, .pulse_two_disable,
    .pulse_three_disable
  );

  // Configuration outputs in mode register layout
  assign cfgv = {20'h00000, pulse_three_disable, pulse_two_disable,
                 pulse_one_disable, pulse_three_power_select,
                 pulse_two_power_select, pulse_one_power_select};

  task summarize();
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
      error_cnt++;
    end
  endtask

  // One bus cycle; answer taken at the edge that sees waitrequest low
  task bus(input logic w, input logic [15:0] a, input logic [31:0] d,
           input logic [3:0] b);
    int n;
    avs_address    <= a;
    avs_write      <= w;
    avs_read       <= !w;
    avs_writedata  <= d;
    avs_byteenable <= b;
    n = 0;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        error_cnt++;
        summarize();
      end
      @(posedge mclk);
    end
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task rd(input logic [15:0] a);
    bus(1'b0, a, 32'h0000_0000, 4'h0);
  endtask

  task wr(input logic [15:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  // Event inputs held for exactly one sampling edge; sign inputs keep their values
  task pulse_events(input logic dsp);
    {react_c_total_sign, react_c_fund_sign} <= {rt, rf};
    {sum_two_sign_in, sum_three_sign_in} <= {s2, s3};
    dsp_cycle_done <= dsp;
    {total_noload_enter, fund_noload_enter, app_noload_enter} <= {tn, fn, an};
    {volt_timeout_evt, curr_timeout_evt, volt_crossing_evt} <= {vt, ct, vz};
    @(posedge mclk);
    dsp_cycle_done <= 1'b0;
    {total_noload_enter, fund_noload_enter, app_noload_enter} <= 9'h000;
    {volt_timeout_evt, curr_timeout_evt, volt_crossing_evt} <= 9'h000;
    @(posedge mclk);
  endtask

  // Free-running 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Main sequence
  initial begin
    seed = 32'hc0c836b7;
    {error_cnt, tests_run, primed, sel, rt, rf, s2, s3} = 0;
    {tn, fn, an, vt, ct, vz} = 18'h00000;
    {rst_n, avs_read, avs_write, dsp_cycle_done} = 4'h0;
    {avs_address, avs_writedata, avs_byteenable} = 52'h0;
    {react_c_total_sign, react_c_fund_sign} = 2'h0;
    {sum_two_sign_in, sum_three_sign_in} = 2'h0;
    {total_noload_enter, fund_noload_enter, app_noload_enter} = 9'h000;
    {volt_timeout_evt, curr_timeout_evt, volt_crossing_evt} = 9'h000;
    {pulse_out_three, pulse_out_two, pulse_out_one} = 3'h7;
    e1 = 32'h0000_0000;
    e2 = 32'h0000_0000;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    // Reset values and an unmapped place
    rd(mef_pkg::IDX_PULSE_MODE);
    chk("mode", {20'h00000, mef_pkg::PM_RESET}, q & 32'hFFF);
    chk("cfg", {20'h00000, mef_pkg::PM_RESET}, cfgv);
    rd(mef_pkg::IDX_STATUS_FIRST);
    chk("first", 32'h0000_0000, q);
    rd(mef_pkg::IDX_STATUS_SECOND);
    chk("second", 32'h0000_0000, q & mef_pkg::SECOND_MASK);
    rd(16'h1234);
    chk("unmapped", mef_pkg::UNMAPPED, q);
    // Random no-load and crossing events, random partial clears
    for (int i = 0; i < 24; i++) begin
      {tn, fn, an} = 9'($random(seed) & $random(seed));
      {vt, ct, vz} = 9'($random(seed) & $random(seed));
      pulse_events(1'b0);
      e2 = e2 | 32'({vz, ct, vt, |an, |fn, |tn});
      cur = {an, fn, tn};
      rd(mef_pkg::IDX_STATUS_SECOND);
      chk("second", e2, q & mef_pkg::SECOND_MASK);
      rd(mef_pkg::IDX_NOLOAD_PHASE);
      chk("phases", 32'(cur), q & 32'(cur));
      clr = $random(seed);
      be = 4'($random(seed));
      bus(1'b1, mef_pkg::IDX_STATUS_SECOND, clr, be);
      bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      e2 = e2 & ~(clr & bm);
    end
    {tn, fn, an, vt, ct, vz} = 18'h00000;
    wr(mef_pkg::IDX_STATUS_SECOND, 32'hFFFF_FFFF);
    // Sign tracking; source switch once both sources agree
    for (int i = 0; i < 16; i++) begin
      if (i == 8) begin
        wr(mef_pkg::IDX_ACC_MODE, 32'h0000_0080);
        sel = 1'b1;
      end
      {rt, rf, s2, s3} = 4'($random(seed));
      if (i == 7) rf = rt;
      pulse_events(1'b1);
      ch = sel ? rf : rt;
      if (primed) e1 = e1 | 32'({s3 != p3, 4'h0, s2 != p2, ch != pr, 12'h0});
      e1 = e1 | 32'h0002_0000;
      {pr, p2, p3, primed} = {ch, s2, s3, 1'b1};
      rd(mef_pkg::IDX_STATUS_FIRST);
      chk("first", e1, q & 32'hFFFF_F000);
      rd(mef_pkg::IDX_SIGN);
      chk("sign", 32'({p3, p2, pr, 6'h00}), q & 32'h1C0);
      wr(mef_pkg::IDX_STATUS_FIRST, 32'hFFFF_FFFF);
      e1 = 32'h0000_0000;
    end
    // Pulse pin falls with the pin enabled and disabled
    for (int i = 0; i < 6; i++) begin
      pm = (12'($random(seed)) & 12'h1FF) | ((i % 2 == 1) ? 12'hE00 : 12'h0);
      wr(mef_pkg::IDX_PULSE_MODE, 32'(pm));
      chk("cfg", 32'(pm), cfgv);
      rd(mef_pkg::IDX_PULSE_MODE);
      chk("mode", 32'(pm), q & 32'hFFF);
      k = i % 3;
      {pulse_out_three, pulse_out_two, pulse_out_one} <= ~(3'b001 << k);
      repeat (3) @(posedge mclk);
      {pulse_out_three, pulse_out_two, pulse_out_one} <= 3'h7;
      repeat (6) @(posedge mclk);
      rd(mef_pkg::IDX_STATUS_FIRST);
      chk("first", 32'h0000_4000 << k, q & 32'hFFFF_F000);
      wr(mef_pkg::IDX_STATUS_FIRST, 32'hFFFF_FFFF);
    end
    // Reduced variant hides reactive sign and fundamental no-load
    wr(mef_pkg::IDX_VARIANT, 32'h0000_0000);
    {rt, rf, fn, tn} = {!rt, !rf, 3'b001, 3'b010};
    pulse_events(1'b1);
    rd(mef_pkg::IDX_STATUS_FIRST);
    chk("first", 32'h0002_0000, q & 32'hFFFF_F000);
    rd(mef_pkg::IDX_STATUS_SECOND);
    chk("second", 32'h0000_0001, q & mef_pkg::SECOND_MASK);
    wr(mef_pkg::IDX_VARIANT, 32'h0000_0003);
    wr(mef_pkg::IDX_STATUS_FIRST, 32'hFFFF_FFFF);
    rd(mef_pkg::IDX_STATUS_FIRST);
    chk("first", 32'h0000_0000, q);
    summarize();
  end
endmodule
`default_nettype wire
